// [hw/dpsc_port.sv]
// serial command port of a dual nonvolatile wiper pair
// assumes serial pins arrive asynchronously and are sampled by clk_sys_in
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - frames are 16 bits, MSB first, shifted while chip select is low.
// - chip select stays low for the frame; execution happens on its rise.
// - bits 15-12 command, 11-8 address, 7-0 data.
// - only frames of a multiple of 16 clocks are executed.
// - misaligned count (not multiple of 4) clears counter and data on rise.
// - a bare chip-select pulse repeats the last command, not after power-up.
// - open-drain output released whenever chip select is high.
// - slave modes 0 and 3: sample on rising clock, drive on falling.
// - outside readback the output shifts out earlier received bits.
// - read commands load the selected value into the data byte.
// - only the two read commands use the output for readback.
// - step and shift commands ignore the data byte.
// - write protect low blocks wiper changes except reload and preset.
// - no-op puts the logic into its low-power state.
// - at power-on the wipers load from their stored settings.
// - preset low sets midscale; its rise reloads from stored settings.
// - a save takes 25 ms, locks the shift register, ready low meanwhile.
// - ready high marks completion of save, write, reload, read, preset.
// - code 0 sets the low-power flag and leaves both wipers unchanged.
module dpsc_port import dpsc_pkg::*; #(
  parameter int unsigned NV_WRITE_CYCLES = DPSC_SAVE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  input wire logic write_protect_n_in,
  input wire logic preset_strobe_n_in,
  output logic ready_out,
  output logic [7:0] wiper0_out,
  output logic [7:0] wiper1_out,
  output logic low_power_out
);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] f;
    dpsc_state_t st;
    logic [3:0] cnt;
    logic any;
    logic [15:0] shreg;
    logic sdo_bit;
    logic [15:0] last;
    logic have_prev;
    logic [7:0] wiper0;
    logic [7:0] wiper1;
    logic low_pwr;
    logic [1:0] mask;
    logic [DPSC_BUSY_W-1:0] busy_cnt;
  } dpsc_regs_t;

  dpsc_regs_t r;
  dpsc_regs_t next_r;
  logic [4:0] settle;
  logic [4:0] flt;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [15:0] cmd_word;
  logic [3:0] cmd;
  logic exec;
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [3:0] mem_raddr;
  logic [7:0] mem_rdata;

  function automatic logic [7:0] dpsc_step(input logic [3:0] c, input logic [7:0] w);
    logic [7:0] v;
    v = w;
    unique case (c[3:1])
      3'b010: v = {1'b0, w[7:1]};
      3'b011: v = (w == 8'h00) ? w : w - 8'h01;
      3'b110: v = w[7] ? DPSC_FULLSCALE : {w[6:0], 1'b1};
      3'b111: v = (w == DPSC_FULLSCALE) ? w : w + 8'h01;
      default: v = w;
    endcase
    return v;
  endfunction : dpsc_step

  // ----------------------------------------------------------------
  // input filtering: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  assign settle = ~(r.s2 ^ r.s3);
  assign flt = (settle & r.s3) | (~settle & r.f);
  assign rise = flt & ~r.f;
  assign fall = ~flt & r.f;

  assign cmd_word = r.any ? r.shreg : r.last;
  assign cmd = cmd_word[DPSC_CMD_MSB:DPSC_CMD_LSB];
  // execute on chip-select rise only for whole 16-bit frames or a bare pulse
  assign exec = rise[DPSC_IN_CS] && r.st == DPSC_ST_IDLE
    && (r.any ? r.cnt == 4'h0 : r.have_prev);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    mem_waddr = 4'h0;
    mem_wdata = 8'h00;
    mem_raddr = 4'h0;
    next_r.s1 = {preset_strobe_n_in, write_protect_n_in, spi_sdi_in, spi_cs_n_in, spi_sclk_in};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.f = flt;
    if (fall[DPSC_IN_CS]) begin
      next_r.cnt = 4'h0;
      next_r.any = 1'b0;
      next_r.sdo_bit = r.shreg[15];
    end
    // sample on rising edge; frozen during a save
    if (rise[DPSC_IN_SCLK] && !r.f[DPSC_IN_CS] && r.st != DPSC_ST_BUSY) begin
      next_r.shreg = {r.shreg[14:0], r.f[DPSC_IN_SDI]};
      next_r.cnt = r.cnt + 4'h1;
      next_r.any = 1'b1;
    end
    if (fall[DPSC_IN_SCLK] && !r.f[DPSC_IN_CS]) begin
      next_r.sdo_bit = r.shreg[15];
    end
    if (rise[DPSC_IN_CS]) begin
      next_r.cnt = 4'h0;
      next_r.any = 1'b0;
      if (r.cnt[1:0] != 2'b00) begin
        next_r.shreg = '0;
      end
    end
    unique case (r.st)
      DPSC_ST_LD0: begin
        next_r.st = DPSC_ST_LD1;
      end
      DPSC_ST_LD1: begin
        mem_raddr = 4'h1;
        if (r.mask[0]) begin
          next_r.wiper0 = mem_rdata;
        end
        next_r.st = DPSC_ST_LD2;
      end
      DPSC_ST_LD2: begin
        if (r.mask[1]) begin
          next_r.wiper1 = mem_rdata;
        end
        next_r.st = DPSC_ST_IDLE;
      end
      DPSC_ST_RD0: begin
        next_r.shreg[DPSC_DATA_MSB:0] = mem_rdata;
        next_r.st = DPSC_ST_IDLE;
      end
      DPSC_ST_BUSY: begin
        if (r.busy_cnt == '0) begin
          next_r.st = DPSC_ST_IDLE;
        end else begin
          next_r.busy_cnt = r.busy_cnt - 1'b1;
        end
      end
      DPSC_ST_PRLOW: begin
        next_r.wiper0 = DPSC_MIDSCALE;
        next_r.wiper1 = DPSC_MIDSCALE;
        if (rise[DPSC_IN_PR]) begin
          next_r.mask = 2'b11;
          next_r.st = DPSC_ST_LD0;
        end
      end
      DPSC_ST_IDLE: begin
        if (exec) begin
          next_r.last = cmd_word;
          next_r.have_prev = 1'b1;
          next_r.low_pwr = (cmd == DPSC_CMD_NOP);
          unique case (cmd)
            DPSC_CMD_NOP: begin
              next_r.low_pwr = 1'b1;
            end
            DPSC_CMD_NV_TO_WIPER: begin
              if (r.f[DPSC_IN_WP]) begin
                next_r.mask = cmd_word[DPSC_SEL_BIT] ? 2'b10 : 2'b01;
                next_r.st = DPSC_ST_LD0;
              end
            end
            DPSC_CMD_SAVE, DPSC_CMD_NV_WRITE: begin
              mem_we = 1'b1;
              if (cmd == DPSC_CMD_SAVE) begin
                mem_waddr = {3'b000, cmd_word[DPSC_SEL_BIT]};
                mem_wdata = cmd_word[DPSC_SEL_BIT] ? r.wiper1 : r.wiper0;
              end else begin
                mem_waddr = cmd_word[DPSC_ADDR_MSB:DPSC_ADDR_LSB];
                mem_wdata = cmd_word[DPSC_DATA_MSB:0];
              end
              next_r.busy_cnt = DPSC_BUSY_W'(NV_WRITE_CYCLES - 1);
              next_r.st = DPSC_ST_BUSY;
            end
            DPSC_CMD_RELOAD: begin
              next_r.mask = 2'b11;
              next_r.st = DPSC_ST_LD0;
            end
            DPSC_CMD_NV_READ: begin
              mem_raddr = cmd_word[DPSC_ADDR_MSB:DPSC_ADDR_LSB];
              next_r.st = DPSC_ST_RD0;
            end
            DPSC_CMD_WIPER_READ: begin
              next_r.shreg[DPSC_DATA_MSB:0] =
                cmd_word[DPSC_SEL_BIT] ? r.wiper1 : r.wiper0;
            end
            DPSC_CMD_WIPER_SET: begin
              if (r.f[DPSC_IN_WP]) begin
                if (cmd_word[DPSC_SEL_BIT]) begin
                  next_r.wiper1 = cmd_word[DPSC_DATA_MSB:0];
                end else begin
                  next_r.wiper0 = cmd_word[DPSC_DATA_MSB:0];
                end
              end
            end
            default: begin
              // steps and shifts: data byte never consulted
              if (r.f[DPSC_IN_WP]) begin
                if (cmd_word[DPSC_ALL_BIT] || !cmd_word[DPSC_SEL_BIT]) begin
                  next_r.wiper0 = dpsc_step(cmd, r.wiper0);
                end
                if (cmd_word[DPSC_ALL_BIT] || cmd_word[DPSC_SEL_BIT]) begin
                  next_r.wiper1 = dpsc_step(cmd, r.wiper1);
                end
              end
            end
          endcase
        end
      end
      default: begin
        next_r.st = DPSC_ST_IDLE;
      end
    endcase
    if (fall[DPSC_IN_PR]) begin
      next_r.wiper0 = DPSC_MIDSCALE;
      next_r.wiper1 = DPSC_MIDSCALE;
      next_r.st = DPSC_ST_PRLOW;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.s1 <= DPSC_IN_IDLE;
      r.s2 <= DPSC_IN_IDLE;
      r.s3 <= DPSC_IN_IDLE;
      r.f <= DPSC_IN_IDLE;
      r.mask <= 2'b11;
      r.st <= DPSC_ST_LD0;
    end else begin
      r <= next_r;
    end
  end

  dpsc_nv_store #(
    .AW(4),
    .DW(8)
  ) u_nv_store (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign spi_sdo_out = 1'b0;
  assign spi_sdo_oe_out = !r.f[DPSC_IN_CS] && !r.sdo_bit;
  assign ready_out = (r.st == DPSC_ST_IDLE);
  assign wiper0_out = r.wiper0;
  assign wiper1_out = r.wiper1;
  assign low_power_out = r.low_pwr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  sdo_release_a: assert property (r.f[DPSC_IN_CS] |-> !spi_sdo_oe_out)
    else $error("serial output driven while chip select high");
  frame_exec_a: assert property (exec && r.any |=> r.last == $past(r.shreg))
    else $error("whole frame not taken as command");
  mislock_clear_a: assert property (rise[DPSC_IN_CS] && r.cnt[1:0] != 2'b00
    |=> r.shreg == 16'h0000 && r.cnt == 4'h0 && $stable(r.last))
    else $error("misaligned frame not discarded");
  shift_in_a: assert property (rise[DPSC_IN_SCLK] && !r.f[DPSC_IN_CS] && r.st != DPSC_ST_BUSY
    && !rise[DPSC_IN_CS] |=> r.shreg == {$past(r.shreg[14:0]), $past(r.f[DPSC_IN_SDI])})
    else $error("serial bit not shifted in");
  wp_block_a: assert property (r.st == DPSC_ST_IDLE && !r.f[DPSC_IN_WP] && !fall[DPSC_IN_PR]
    |=> $stable(r.wiper0) && $stable(r.wiper1))
    else $error("wiper changed under write protect");
  save_lock_a: assert property (r.st == DPSC_ST_BUSY && !fall[DPSC_IN_PR]
    |-> !ready_out ##1 $stable(r.shreg))
    else $error("shift register not locked during save");
  nop_idle_a: assert property (exec && cmd == DPSC_CMD_NOP && !fall[DPSC_IN_PR]
    |=> low_power_out && $stable(r.wiper0) && $stable(r.wiper1) && ready_out)
    else $error("no-op changed state");
  wiper_read_a: assert property (exec && cmd == DPSC_CMD_WIPER_READ && !cmd_word[DPSC_SEL_BIT]
    |=> r.shreg[7:0] == $past(r.wiper0))
    else $error("wiper value not loaded for readback");
  preset_mid_a: assert property (fall[DPSC_IN_PR]
    |=> wiper0_out == DPSC_MIDSCALE && wiper1_out == DPSC_MIDSCALE && !ready_out)
    else $error("preset did not set midscale");
  repeat_cmd_a: assert property (rise[DPSC_IN_CS] && !r.any && r.have_prev
    && r.st == DPSC_ST_IDLE |-> exec && cmd_word == r.last)
    else $error("bare pulse did not repeat command");

endmodule : dpsc_port
`default_nettype wire

// [hw/dpsc_pkg.sv]
// constants, commands and states of the dual-wiper serial command port
// assumes a 50 MHz system clock; shared by the port and its setting store
`default_nettype none
package dpsc_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int DPSC_FRAME_BITS = 16;
  localparam int DPSC_CMD_MSB = 15;
  localparam int DPSC_CMD_LSB = 12;
  localparam int DPSC_ADDR_MSB = 11;
  localparam int DPSC_ADDR_LSB = 8;
  localparam int DPSC_SEL_BIT = 8;
  localparam int DPSC_ALL_BIT = 12;
  localparam int DPSC_DATA_MSB = 7;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] DPSC_CMD_NOP = 4'h0;
  localparam logic [3:0] DPSC_CMD_NV_TO_WIPER = 4'h1;
  localparam logic [3:0] DPSC_CMD_SAVE = 4'h2;
  localparam logic [3:0] DPSC_CMD_NV_WRITE = 4'h3;
  localparam logic [3:0] DPSC_CMD_RELOAD = 4'h8;
  localparam logic [3:0] DPSC_CMD_NV_READ = 4'h9;
  localparam logic [3:0] DPSC_CMD_WIPER_READ = 4'hA;
  localparam logic [3:0] DPSC_CMD_WIPER_SET = 4'hB;

  // ----------------------------------------------------------------
  // values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] DPSC_MIDSCALE = 8'h80;
  localparam logic [7:0] DPSC_FULLSCALE = 8'hFF;
  localparam int DPSC_CLK_KHZ = 50000;
  localparam int DPSC_SAVE_TIME_MS = 25;
  localparam int DPSC_SAVE_CYCLES = DPSC_SAVE_TIME_MS * DPSC_CLK_KHZ;
  localparam int DPSC_BUSY_W = 21;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int DPSC_IN_SCLK = 0;
  localparam int DPSC_IN_CS = 1;
  localparam int DPSC_IN_SDI = 2;
  localparam int DPSC_IN_WP = 3;
  localparam int DPSC_IN_PR = 4;
  localparam logic [4:0] DPSC_IN_IDLE = 5'h1A;

  typedef enum logic [2:0] {
    DPSC_ST_LD0 = 3'h0,
    DPSC_ST_LD1 = 3'h1,
    DPSC_ST_LD2 = 3'h3,
    DPSC_ST_IDLE = 3'h2,
    DPSC_ST_RD0 = 3'h6,
    DPSC_ST_BUSY = 3'h7,
    DPSC_ST_PRLOW = 3'h5
  } dpsc_state_t;

endpackage : dpsc_pkg
`default_nettype wire

// [hw/dpsc_nv_store.sv]
// nonvolatile setting store: one write port, registered read data
// assumes writes and reads come from the port logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module dpsc_nv_store import dpsc_pkg::*; #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [2**AW];

  // ----------------------------------------------------------------
  // storage, factory state midscale
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= DW'(DPSC_MIDSCALE);
      end
      rdata_out <= '0;
    end else begin
      if (we_in) begin
        mem[waddr_in] <= wdata_in;
      end
      rdata_out <= mem[raddr_in];
    end
  end

endmodule : dpsc_nv_store
`default_nettype wire

// [sim/dpsc_host_model.sv]
// host master model driving the serial command port in mode 0
// assumes the bench feeds back the resolved open-drain line with its pull-up
`timescale 1ns/100ps
`default_nettype none
module dpsc_host_model (
  input wire logic clk_sys_in,
  input wire logic sdo_line_in,
  output logic spi_sclk_out,
  output logic spi_cs_n_out,
  output logic spi_sdi_out
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // link clock stands still low outside frames
  initial begin
    spi_sclk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_sdi_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : hold

  // ----------------------------------------------------------------
  // one frame, msb first; rx gathers the line late in each high phase
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] word, input int nbits, output logic [31:0] rx);
    rx = 32'h0;
    spi_cs_n_out <= 1'b0;
    hold(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_sdi_out <= word[i];
      hold(4);
      spi_sclk_out <= 1'b1;
      hold(4);
      rx = {rx[30:0], sdo_line_in};
      spi_sclk_out <= 1'b0;
    end
    hold(4);
    spi_cs_n_out <= 1'b1;
    // released data line must not keep the last bit
    spi_sdi_out <= ~spi_sdi_out;
    hold(8);
  endtask : xfer

  // chip select strobe with no clock activity
  task automatic cs_pulse();
    spi_cs_n_out <= 1'b0;
    hold(8);
    spi_cs_n_out <= 1'b1;
    hold(8);
  endtask : cs_pulse
endmodule : dpsc_host_model
`default_nettype wire

// [sim/test_dual_pot_serial_command_port.sv]
// self-checking bench for the serial command port
// assumes the host model above and a short save time of 20 cycles
`timescale 1ns/100ps
`default_nettype none
module test_dual_pot_serial_command_port;
  import dpsc_pkg::*;
  logic clk_sys_in, resetn_in, write_protect_n_in, preset_strobe_n_in;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo_out, spi_sdo_oe_out, sdo_line;
  logic ready_out, low_power_out;
  logic [7:0] wiper0_out, wiper1_out;
  logic [31:0] rx;
  int fails = 0;
  int comparisons = 0;

  // open-drain line with pull-up
  assign sdo_line = spi_sdo_oe_out ? spi_sdo_out : 1'b1;

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  dpsc_port #(.NV_WRITE_CYCLES(20)) dut (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .spi_sclk_in(spi_sclk),
    .spi_cs_n_in(spi_cs_n),
    .spi_sdi_in(spi_sdi),
    .spi_sdo_out(spi_sdo_out),
    .spi_sdo_oe_out(spi_sdo_oe_out),
    .write_protect_n_in(write_protect_n_in),
    .preset_strobe_n_in(preset_strobe_n_in),
    .ready_out(ready_out),
    .wiper0_out(wiper0_out),
    .wiper1_out(wiper1_out),
    .low_power_out(low_power_out)
  );

  dpsc_host_model host (
    .clk_sys_in(clk_sys_in),
    .sdo_line_in(sdo_line),
    .spi_sclk_out(spi_sclk),
    .spi_cs_n_out(spi_cs_n),
    .spi_sdi_out(spi_sdi)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_out !== 1'b1 && n < 200) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (ready_out !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask : wait_ready

  task automatic send(input logic [15:0] w);
    host.xfer({16'h0000, w}, 16, rx);
    wait_ready();
  endtask : send

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    resetn_in = 1'b0;
    write_protect_n_in = 1'b1;
    preset_strobe_n_in = 1'b1;
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    @(posedge clk_sys_in);
    wait_ready();
    check(wiper0_out, 8'h80);
    check(wiper1_out, 8'h80);
    host.cs_pulse();
    wait_ready();
    check(wiper0_out, 8'h80);
    check(low_power_out, 1'b0);
    send(16'hB040);
    check(wiper0_out, 8'h40);
    check(spi_sdo_oe_out, 1'b0);
    send(16'hA000);
    send(16'h0000);
    check(rx, 32'h0000A040);
    check(low_power_out, 1'b1);
    host.xfer(32'hB133B055, 32, rx);
    wait_ready();
    check(rx[15:0], 16'hB133);
    check(wiper0_out, 8'h55);
    check(wiper1_out, 8'h80);
    check(low_power_out, 1'b0);
    send(16'hE0FF);
    check(wiper0_out, 8'h56);
    host.cs_pulse();
    wait_ready();
    check(wiper0_out, 8'h57);
    host.xfer(32'h0000B011, 12, rx);
    wait_ready();
    check(wiper0_out, 8'h57);
    host.xfer(32'h0000B011, 15, rx);
    wait_ready();
    check(wiper0_out, 8'h57);
    send(16'hB011);
    check(wiper0_out, 8'h11);
    host.xfer(32'h00002000, 16, rx);
    check(ready_out, 1'b0);
    wait_ready();
    check(ready_out, 1'b1);
    send(16'hB022);
    write_protect_n_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    send(16'hB010);
    check(wiper0_out, 8'h22);
    send(16'h8000);
    check(wiper0_out, 8'h11);
    send(16'h0000);
    write_protect_n_in <= 1'b1;
    preset_strobe_n_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    check(wiper0_out, 8'h80);
    check(wiper1_out, 8'h80);
    preset_strobe_n_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    wait_ready();
    check(wiper0_out, 8'h11);
    send(16'h9000);
    send(16'h0000);
    check(rx, 32'h00009011);
    close_out();
  end
endmodule : test_dual_pot_serial_command_port
`default_nettype wire
